/* core/fgpr_pkg.sv */
// Register map, field layout and reset values of the fuel-gauge parameter bank
package fgpr_pkg;
  localparam logic [7:0] FGPR_ADDR_RES_10C   = 8'h1A;
  localparam logic [7:0] FGPR_ADDR_RES_20C   = 8'h1B;
  localparam logic [7:0] FGPR_ADDR_RES_30C   = 8'h1C;
  localparam logic [7:0] FGPR_ADDR_RES_40C   = 8'h1D;
  localparam logic [7:0] FGPR_ADDR_RES_60C   = 8'h1E;
  localparam logic [7:0] FGPR_ADDR_COEF      = 8'h1F;
  localparam logic [7:0] FGPR_ADDR_TEMP      = 8'h20;
  localparam logic [7:0] FGPR_ADDR_CHARGE    = 8'h21;
  localparam logic [7:0] FGPR_ADDR_VOLT_HIGH = 8'h22;
  localparam logic [7:0] FGPR_ADDR_VOLT_LOW  = 8'h23;
  localparam logic [7:0] FGPR_ADDR_RESULT_CLR = 8'h25;

  localparam int          FGPR_RES_POINTS   = 5;
  localparam logic [7:0]  FGPR_RES_RESET    = 8'h3F;
  localparam logic [1:0]  FGPR_MULT_RESET   = 2'h0;
  localparam logic [3:0]  FGPR_CHG_RESET    = 4'h8;
  localparam logic        FGPR_SRC_RESET    = 1'h0;
  localparam logic [5:0]  FGPR_TEMP_RESET   = 6'h1B;
  localparam logic [6:0]  FGPR_CHARGE_MAX   = 7'h64;
  localparam int          FGPR_CLR_BIT      = 7;
  localparam int          FGPR_SRC_BIT      = 6;
  localparam int          FGPR_MULT_LSB     = 4;
  localparam int          FGPR_VOLT_W       = 13;
  localparam int          FGPR_VOLT_SPLIT   = 5;
  localparam int          FGPR_MULT_W       = 2;
  localparam int          FGPR_CHG_LSB      = 0;
  localparam int          FGPR_CHG_W        = 4;
  localparam int          FGPR_TEMP_LSB     = 0;
  localparam int          FGPR_TEMP_W       = 6;
  localparam int          FGPR_CHARGE_W     = 7;
  localparam logic [7:0]  FGPR_RDATA_RESET  = 8'h00;
endpackage : fgpr_pkg

/* core/fgpr_regs.sv */
// Fuel-gauge parameter and result register bank on the byte register port
//
// What this block does
// RULE1: Five read/write resistance-table bytes at 0x1A..0x1E reset to 0x3F, 32 milliohm per count.
// RULE2: Coefficient bits 5:4 at 0x1F are read/write, reset 00, picking the empty-charge multiplier 1x/2x/4x/8x.
// RULE3: Coefficient bits 3:0 at 0x1F are read/write, reset 1000, charging coefficient 0.75 plus value over 32.
// RULE4: Temperature bit 6 at 0x20 resets to 0 and selects thermistor input (0) or host value (1).
// RULE5: Temperature bits 5:0 hold host temperature as value minus 2 degrees, reset 11011.
// RULE6: Register 0x21 reads charge level in bits 6:0, limited to 0..100, bit 7 zero.
// RULE7: Register 0x22 reads voltage bits 12:5 in millivolt units.
// RULE8: Register 0x23 reads voltage bits 4:0 in its bits 7:3, bits 2:0 zero.
// RULE9: Writing 1 to bit 7 at 0x25 clears the charge level and both voltage registers; a result_valid in the same cycle loads the new result instead.
// RULE10: Unused bits read zero and writes to read-only or unused bits change nothing.
`timescale 1ns/100ps
`default_nettype none
module fgpr_regs
  import fgpr_pkg::*;
(
  input  wire logic                   core_clk,           // 50 MHz clock
  input  wire logic                   sys_rst,            // Synchronous reset, active high
  input  wire logic                   reg_wr,             // Register write strobe
  input  wire logic                   reg_rd,             // Register read strobe
  input  wire logic [7:0]             reg_addr,           // Register address
  input  wire logic [7:0]             reg_wdata,          // Write data
  output logic      [7:0]             reg_rdata,          // Read data, registered
  input  wire logic                   result_valid,       // Gauge result update pulse
  input  wire logic [6:0]             result_charge,      // Gauge charge level percent
  input  wire logic [FGPR_VOLT_W-1:0] result_voltage,     // Gauge voltage, mV
  input  wire logic [5:0]             thermistor_input,   // Thermistor temperature code
  output logic [7:0]                  resistance_at_10c,  // Resistance table, 10 C
  output logic [7:0]                  resistance_at_20c,  // Resistance table, 20 C
  output logic [7:0]                  resistance_at_30c,  // Resistance table, 30 C
  output logic [7:0]                  resistance_at_40c,  // Resistance table, 40 C
  output logic [7:0]                  resistance_at_60c,  // Resistance table, 60 C
  output logic [1:0]                  low_charge_resistance_multiplier, // Empty-charge multiplier code
  output logic [3:0]                  charging_resistance_coefficient,  // Charging coefficient code
  output logic                        temperature_source_select,        // 1 = host temperature
  output logic [5:0]                  gauge_temperature                 // Temperature the gauge uses
);

  logic [7:0]                 res_val [FGPR_RES_POINTS];
  logic [FGPR_MULT_W-1:0]     mult_ff;
  logic [FGPR_CHG_W-1:0]      chg_ff;
  logic                       src_ff;
  logic [FGPR_TEMP_W-1:0]     temp_ff;
  logic [FGPR_CHARGE_W-1:0]   charge_ff;
  logic [FGPR_VOLT_W-1:0]     volt_ff;
  logic [7:0]                 rdata_ff;
  logic [7:0]                 nxt_rdata;
  logic [FGPR_CHARGE_W-1:0]   nxt_charge;
  logic [FGPR_RES_POINTS-1:0] res_hit;
  logic                       coef_hit;
  logic                       temp_hit;
  logic                       clr_hit;
  logic                       coef_wr;
  logic                       temp_wr;
  logic                       result_clr;

  // Address decode for the control registers
  assign coef_hit   = (reg_addr == FGPR_ADDR_COEF);
  assign temp_hit   = (reg_addr == FGPR_ADDR_TEMP);
  assign clr_hit    = (reg_addr == FGPR_ADDR_RESULT_CLR);
  assign coef_wr    = reg_wr && coef_hit;
  assign temp_wr    = reg_wr && temp_hit;
  assign result_clr = reg_wr && clr_hit && reg_wdata[FGPR_CLR_BIT]; // RULE9

  // One decode and one byte per table point
  for (genvar g = 0; g < FGPR_RES_POINTS; g++)
  begin : g_res
    logic [7:0] point_ff;

    assign res_hit[g] = (reg_addr == FGPR_ADDR_RES_10C + 8'(g));

    always_ff @(posedge core_clk)
    begin
      if (sys_rst)
      begin
        point_ff <= FGPR_RES_RESET; // RULE1
      end
      else if (reg_wr && res_hit[g])
      begin
        point_ff <= reg_wdata; // RULE1
      end
    end

    assign res_val[g] = point_ff;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mult_ff <= FGPR_MULT_RESET; // RULE2
    end
    else if (coef_wr)
    begin
      mult_ff <= reg_wdata[FGPR_MULT_LSB +: FGPR_MULT_W]; // RULE2
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      chg_ff <= FGPR_CHG_RESET; // RULE3
    end
    else if (coef_wr)
    begin
      chg_ff <= reg_wdata[FGPR_CHG_LSB +: FGPR_CHG_W]; // RULE3
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      src_ff <= FGPR_SRC_RESET; // RULE4
    end
    else if (temp_wr)
    begin
      src_ff <= reg_wdata[FGPR_SRC_BIT]; // RULE4
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      temp_ff <= FGPR_TEMP_RESET; // RULE5
    end
    else if (temp_wr)
    begin
      temp_ff <= reg_wdata[FGPR_TEMP_LSB +: FGPR_TEMP_W]; // RULE5
    end
  end

  // Gauge may report above full; the register never does
  always_comb
  begin
    nxt_charge = result_charge;
    if (result_charge > FGPR_CHARGE_MAX)
      nxt_charge = FGPR_CHARGE_MAX; // RULE6
  end

  // A fresh result beats a same-cycle clear, so no reading is lost
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      charge_ff <= '0;
    end
    else if (result_valid)
    begin
      charge_ff <= nxt_charge; // RULE6
    end
    else if (result_clr)
    begin
      charge_ff <= '0; // RULE9
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      volt_ff <= '0;
    end
    else if (result_valid)
    begin
      volt_ff <= result_voltage; // RULE7
    end
    else if (result_clr)
    begin
      volt_ff <= '0; // RULE9
    end
  end

  // Temperature actually fed to the gauge
  always_comb
  begin
    if (src_ff)
      gauge_temperature = temp_ff; // RULE5
    else
      gauge_temperature = thermistor_input; // RULE4
  end

  always_comb
  begin
    nxt_rdata = FGPR_RDATA_RESET; // RULE10
    case (reg_addr)
      FGPR_ADDR_RES_10C:   nxt_rdata = res_val[0];
      FGPR_ADDR_RES_20C:   nxt_rdata = res_val[1];
      FGPR_ADDR_RES_30C:   nxt_rdata = res_val[2];
      FGPR_ADDR_RES_40C:   nxt_rdata = res_val[3];
      FGPR_ADDR_RES_60C:   nxt_rdata = res_val[4];
      FGPR_ADDR_COEF:      nxt_rdata = {2'h0, mult_ff, chg_ff}; // RULE10
      FGPR_ADDR_TEMP:      nxt_rdata = {1'h0, src_ff, temp_ff}; // RULE10
      FGPR_ADDR_CHARGE:    nxt_rdata = {1'h0, charge_ff}; // RULE6
      FGPR_ADDR_VOLT_HIGH: nxt_rdata = volt_ff[FGPR_VOLT_W-1:FGPR_VOLT_SPLIT]; // RULE7
      FGPR_ADDR_VOLT_LOW:  nxt_rdata = {volt_ff[FGPR_VOLT_SPLIT-1:0], 3'h0}; // RULE8
      default:             nxt_rdata = FGPR_RDATA_RESET;
    endcase
  end

  // Read data holds between reads, so idle address changes are harmless
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rdata_ff <= FGPR_RDATA_RESET;
    end
    else if (reg_rd)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata                        = rdata_ff;
  assign resistance_at_10c                = res_val[0];
  assign resistance_at_20c                = res_val[1];
  assign resistance_at_30c                = res_val[2];
  assign resistance_at_40c                = res_val[3];
  assign resistance_at_60c                = res_val[4];
  assign low_charge_resistance_multiplier = mult_ff;
  assign charging_resistance_coefficient  = chg_ff;
  assign temperature_source_select        = src_ff;

endmodule : fgpr_regs
`default_nettype wire

/* sim/fgpr_regs_checker.sv */
// Port assertions for the parameter bank
`timescale 1ns/100ps
`default_nettype none
module fgpr_regs_checker (
  input wire logic       core_clk,                         // Clock
  input wire logic       sys_rst,                          // Reset
  input wire logic       reg_wr,                           // Write
  input wire logic       reg_rd,                           // Read
  input wire logic [7:0] reg_addr,                         // Address
  input wire logic [7:0] reg_wdata,                        // Wdata
  input wire logic [7:0] reg_rdata,                        // Rdata
  input wire logic [5:0] thermistor_input,                 // Thermistor
  input wire logic [7:0] resistance_at_10c,                // Table
  input wire logic [1:0] low_charge_resistance_multiplier, // Mult
  input wire logic [3:0] charging_resistance_coefficient,  // Coef
  input wire logic       temperature_source_select,        // Source
  input wire logic [5:0] gauge_temperature                 // Temp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire wc = reg_wr && reg_addr == 8'h1F;
  wire wt = reg_wr && reg_addr == 8'h20;
  AST_TABLE: assert property (reg_wr && reg_addr == 8'h1A |=> resistance_at_10c == $past(reg_wdata))
    else $error("table write lost");
  AST_INIT: assert property (disable iff (1'b0) sys_rst |=> resistance_at_10c == 8'h3F
    && charging_resistance_coefficient == 4'h8 && !temperature_source_select) else $error("bad reset");
  AST_MULT: assert property (wc |=> low_charge_resistance_multiplier == $past(reg_wdata[5:4]))
    else $error("mult write lost");
  AST_COEF: assert property (wc |=> charging_resistance_coefficient == $past(reg_wdata[3:0]))
    else $error("coef write lost");
  AST_THERM: assert property (!temperature_source_select |-> gauge_temperature == thermistor_input)
    else $error("thermistor not used");
  AST_HOST: assert property (wt && reg_wdata[6] |=> gauge_temperature == $past(reg_wdata[5:0]))
    else $error("host temp not used");
  AST_CHARGE: assert property (reg_rd && reg_addr == 8'h21 |=> reg_rdata <= 8'h64)
    else $error("charge over range");
  AST_LOWBITS: assert property (reg_rd && reg_addr == 8'h23 |=> reg_rdata[2:0] == 3'h0)
    else $error("low bits set");
  AST_KEEP: assert property (!wc |=> $stable(charging_resistance_coefficient))
    else $error("coef changed");
  cover property (wc);
  cover property (wt && reg_wdata[6]);
  cover property (reg_rd && reg_addr == 8'h21 ##1 reg_rdata == 8'h64);
endmodule : fgpr_regs_checker
bind fgpr_regs fgpr_regs_checker chk (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .thermistor_input, .resistance_at_10c, .low_charge_resistance_multiplier, .charging_resistance_coefficient,
  .temperature_source_select, .gauge_temperature);
`default_nettype wire

/* sim/fgpr_host.sv */
// Host model on the register port
`timescale 1ns/100ps
`default_nettype none
module fgpr_host (
  input  wire logic       core_clk,  // Clock
  output var  logic       reg_wr,    // Write
  output var  logic       reg_rd,    // Read
  output var  logic [7:0] reg_addr,  // Address
  output var  logic [7:0] reg_wdata  // Wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Bus inverted after release so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : xfer
endmodule : fgpr_host
`default_nettype wire

/* sim/fgpr_regs_bench.sv */
// Self-checking bench for the parameter bank
`timescale 1ns/100ps
`default_nettype none
module fgpr_regs_bench;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        result_valid = 1'b0;
  logic [6:0]  result_charge = 7'h0;
  logic [12:0] result_voltage = 13'h0;
  logic [5:0]  thermistor_input = 6'h05;
  logic        reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, k;
  logic [5:0]  gtemp;
  logic [7:0]  r10, r20, r30, r40, r60;
  logic [1:0]  mult;
  logic [3:0]  coef;
  logic        src;
  logic [7:0]  rv [0:9] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h08, 8'h1B, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wv [0:7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h7F, 8'h00};
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #10 core_clk = ~core_clk;
  fgpr_host p (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  fgpr_regs uut (.core_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .result_valid,
    .result_charge, .result_voltage, .thermistor_input, .resistance_at_10c(r10), .resistance_at_20c(r20),
    .resistance_at_30c(r30), .resistance_at_40c(r40), .resistance_at_60c(r60),
    .low_charge_resistance_multiplier(mult), .charging_resistance_coefficient(coef),
    .temperature_source_select(src), .gauge_temperature(gtemp));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    p.xfer(1'b0, a, 8'h00);
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic summarize;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 1000)
    begin
      fails = fails + 1;
      summarize();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(8'h1A + 8'(i), rv[i]);
    chk("gauge_temperature", 8'h05, {2'h0, gtemp});
    for (int i = 0; i < 8; i++) p.xfer(1'b1, 8'h1A + 8'(i), 8'hFF);
    for (int i = 0; i < 8; i++) rd(8'h1A + 8'(i), wv[i]);
    chk("gauge_temperature", 8'h3F, {2'h0, gtemp});
    chk("resistance_at_10c", 8'hFF, r10);
    chk("resistance_at_20c", 8'hFF, r20);
    chk("resistance_at_30c", 8'hFF, r30);
    chk("resistance_at_40c", 8'hFF, r40);
    chk("resistance_at_60c", 8'hFF, r60);
    chk("low_charge_resistance_multiplier", 8'h03, {6'h0, mult});
    chk("charging_resistance_coefficient", 8'h0F, {4'h0, coef});
    chk("temperature_source_select", 8'h01, {7'h0, src});
    for (k = 8'h0; k < 8'h4; k++)
    begin
      p.xfer(1'b1, 8'h1F, 8'hC0 | k * 8'h11);
      rd(8'h1F, k * 8'h11);
    end
    @(posedge core_clk);
    result_valid <= 1'b1;
    result_charge <= 7'd120;
    result_voltage <= 13'h1ABC;
    @(posedge core_clk);
    result_valid <= 1'b0;
    rd(8'h21, 8'h64);
    rd(8'h22, 8'hD5);
    rd(8'h23, 8'hE0);
    p.xfer(1'b1, 8'h25, 8'h80);
    for (int i = 0; i < 4; i++) rd(8'h21 + 8'(i), 8'h00);
    fork
      p.xfer(1'b1, 8'h25, 8'h80);
      begin
        @(posedge core_clk);
        result_valid <= 1'b1;
        result_charge <= 7'd42;
        @(posedge core_clk);
        result_valid <= 1'b0;
      end
    join
    rd(8'h21, 8'h2A);
    p.xfer(1'b1, 8'h20, 8'h01);
    #1;
    chk("gauge_temperature", 8'h05, {2'h0, gtemp});
    @(posedge core_clk);
    thermistor_input <= 6'h2A;
    @(posedge core_clk);
    #1;
    chk("gauge_temperature", 8'h2A, {2'h0, gtemp});
    summarize();
  end
endmodule : fgpr_regs_bench
`default_nettype wire
